// File: core/cpu_decode_pkg.sv
package cpu_decode_pkg;
  // ==========================================================
  // Flag register layout and reset values
  localparam int         FLAG_V    = 7;
  localparam int         FLAG_H    = 4;
  localparam int         FLAG_I    = 3;
  localparam int         FLAG_N    = 2;
  localparam int         FLAG_Z    = 1;
  localparam int         FLAG_C    = 0;
  localparam logic [7:0]  FLAGS_RST = 8'h08;
  localparam logic [15:0] SP_RST    = 16'h00FF;
  localparam logic [15:0] HX_RST    = 16'h0000;
  localparam logic [15:0] PC_RST    = 16'h0000;
  // ==========================================================
  // Register map, byte addresses on the bus
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_START  = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_PTRS   = 8'h0C;
  localparam logic [7:0] OFS_PC     = 8'h10;
  localparam int         CTRL_RUN   = 0;
  localparam int         STAT_HALT  = 16;
  localparam int         STAT_BUSY  = 17;
  // ==========================================================
  // Opcodes and opcode nibbles
  localparam logic [7:0] OPC_PFX_SP  = 8'h9E;
  localparam logic [7:0] OPC_AIS     = 8'hA7;
  localparam logic [7:0] OPC_AIX     = 8'hAF;
  localparam logic [7:0] OPC_BCC     = 8'h24;
  localparam logic [7:0] OPC_COMPARE_BRANCH_EQUAL_XP = 8'h71;
  localparam logic [7:0] OPC_COMPARE_BRANCH_EQUAL_OP = 8'h61;
  localparam logic [7:0] OPC_MOV_XP  = 8'h7E;
  localparam logic [7:0] OPC_LDHX_I  = 8'h45;
  localparam logic [3:0] NIB_ADC = 4'h9;
  localparam logic [3:0] NIB_ADD = 4'hB;
  localparam logic [3:0] NIB_ASL = 4'h8;
  localparam logic [3:0] NIB_ASR = 4'h7;
  localparam logic [3:0] MN_IMM  = 4'hA;
  localparam logic [3:0] MN_DIR  = 4'hB;
  localparam logic [3:0] MN_EXT  = 4'hC;
  localparam logic [3:0] MN_IX2  = 4'hD;
  localparam logic [3:0] MN_IX1  = 4'hE;
  localparam logic [3:0] MN_IX   = 4'hF;
  localparam logic [3:0] SN_DIR  = 4'h3;
  localparam logic [3:0] SN_INHA = 4'h4;
  localparam logic [3:0] SN_INHX = 4'h5;
  localparam logic [3:0] SN_IX1  = 4'h6;
  localparam logic [3:0] SN_IX   = 4'h7;
  // ==========================================================
  // Types
  typedef enum logic [3:0] {
    ST_IDLE, ST_OPC, ST_PFX, ST_B1, ST_B2, ST_DATA, ST_WR, ST_FREE, ST_HALT
  } state_t;
  typedef enum logic [3:0] {
    implied_mode, literal_operand_mode, literal_long_mode, direct_mode,
    full_address_mode, index_pair_mode, index_postinc_mode,
    index_offset_short_mode, index_offset_short_postinc_mode,
    index_offset_long_mode, stack_offset_short_mode, stack_offset_long_mode,
    relative_mode
  } amode_t;
  typedef enum logic [3:0] {
    OP_ILL, OP_ADC, OP_ADD, stack_adjust_immediate, index_adjust_immediate,
    shift_left_arith, shift_right_arith, branch_carry_clear,
    compare_branch_equal, OP_MOV, OP_LDHX
  } op_t;
  typedef struct packed {
    amode_t     mode;
    op_t        op;
    logic [1:0] nbytes;
    logic       use_x;
  } dec_t;
  typedef struct packed {
    logic [15:0] addr;
    logic        rd;
    logic        wr;
    logic [7:0]  wdata;
  } mem_req_t;
endpackage : cpu_decode_pkg

// File: core/cpu_operand_decode_alu.sv
// How it works
// - overflow bit 7, half-carry bit 4
// - mask 3, negative 2, zero 1, carry 0
// - direct page: high address byte zero
// - branch adds signed offset to next address
// - short index offset added unsigned
// - long offsets wrap in 16 bits
// - post-increment for compare-branch and move only
// - full address: high byte first
// - long offset: upper byte first
// - literal: one byte or high-then-low pair
// - stack-relative with short or long offset
// - full address reaches whole space
// - stack adjust: sign-extend, 2 cycles, flags kept
// - index adjust: sign-extend, 2 cycles, flags kept
// - branch if carry clear, 3 cycles
// - short stack offset added unsigned
`timescale 1ns/1ps
module cpu_operand_decode_alu
  import cpu_decode_pkg::*;
(
  input  wire logic                     clk_sys,   // System clock
  input  wire logic                     reset_n,   // Async reset
  input  wire logic                     hsel,      // Slave select
  input  wire logic [31:0]              haddr,     // Address
  input  wire logic [1:0]               htrans,    // Transfer type
  input  wire logic                     hwrite,    // Write
  input  wire logic [2:0]               hsize,     // Size
  input  wire logic [31:0]              hwdata,    // Write data
  input  wire logic                     hready,    // Bus ready
  output logic      [31:0]              hrdata,    // Read data
  output logic                          hreadyout, // Slave ready
  output logic                          hresp,     // Response
  output cpu_decode_pkg::mem_req_t      mem_req,   // Memory request
  input  wire logic [7:0]               mem_rdata  // Memory read data
);
  import cpu_decode_pkg::*;

  state_t      st_ff, nxt_st;
  dec_t        dec_ff, nxt_dec, dn;
  mem_req_t    nxt_req;
  logic [7:0]  a_ff, nxt_a, flags_ff, nxt_flags, b1_ff, nxt_b1;
  logic [15:0] hx_ff, nxt_hx, sp_ff, nxt_sp, pc_ff, nxt_pc, start_pc_ff, ea;
  logic        halt_ff, nxt_halt, run_ff, wr_pend_ff;
  logic [7:0]  wr_addr_ff, lo, hi;
  logic        go_fetch, start_op, last_byte;
  logic [15:0] res16;

  // ==========================================================
  // Helpers
  function automatic dec_t decode(input logic pfx, input logic [7:0] opc);
    dec_t d;
    d = '{mode: implied_mode, op: OP_ILL, nbytes: 2'd0, use_x: 1'b0};
    if (!pfx && opc == OPC_AIS) d = '{literal_operand_mode, stack_adjust_immediate, 2'd1, 1'b0};
    else if (!pfx && opc == OPC_AIX) d = '{literal_operand_mode, index_adjust_immediate, 2'd1, 1'b0};
    else if (!pfx && opc == OPC_BCC) d = '{relative_mode, branch_carry_clear, 2'd1, 1'b0};
    else if (!pfx && opc == OPC_COMPARE_BRANCH_EQUAL_XP) d = '{index_postinc_mode, compare_branch_equal, 2'd1, 1'b0};
    else if (!pfx && opc == OPC_COMPARE_BRANCH_EQUAL_OP)
      d = '{index_offset_short_postinc_mode, compare_branch_equal, 2'd2, 1'b0};
    else if (!pfx && opc == OPC_MOV_XP) d = '{index_postinc_mode, OP_MOV, 2'd1, 1'b0};
    else if (!pfx && opc == OPC_LDHX_I) d = '{literal_long_mode, OP_LDHX, 2'd2, 1'b0};
    else if (opc[3:0] == NIB_ADC || opc[3:0] == NIB_ADD)
    begin
      d.op = (opc[3:0] == NIB_ADC) ? OP_ADC : OP_ADD;
      unique case (opc[7:4])
        MN_IMM: d.mode = pfx ? implied_mode : literal_operand_mode;
        MN_DIR: d.mode = pfx ? implied_mode : direct_mode;
        MN_EXT: d.mode = pfx ? implied_mode : full_address_mode;
        MN_IX2: d.mode = pfx ? stack_offset_long_mode : index_offset_long_mode;
        MN_IX1: d.mode = pfx ? stack_offset_short_mode : index_offset_short_mode;
        MN_IX:  d.mode = pfx ? implied_mode : index_pair_mode;
        default: d.mode = implied_mode;
      endcase
      if (d.mode == implied_mode) d.op = OP_ILL;
    end
    else if (opc[3:0] == NIB_ASL || opc[3:0] == NIB_ASR)
    begin
      d.op = (opc[3:0] == NIB_ASL) ? shift_left_arith : shift_right_arith;
      d.use_x = (opc[7:4] == SN_INHX);
      unique case (opc[7:4])
        SN_DIR:  d.mode = direct_mode;
        SN_INHA: d.mode = implied_mode;
        SN_INHX: d.mode = implied_mode;
        SN_IX1:  d.mode = pfx ? stack_offset_short_mode : index_offset_short_mode;
        SN_IX:   d.mode = index_pair_mode;
        default: d.op = OP_ILL;
      endcase
      if (pfx && opc[7:4] != SN_IX1) d.op = OP_ILL;
    end
    unique case (d.mode)
      implied_mode, index_pair_mode: d.nbytes = 2'd0;
      full_address_mode, index_offset_long_mode, stack_offset_long_mode: d.nbytes = 2'd2;
      index_offset_short_postinc_mode, literal_long_mode: d.nbytes = 2'd2;
      default: d.nbytes = 2'd1;
    endcase
    return d;
  endfunction : decode

  // Returns the new flags above the 8-bit result.
  function automatic logic [15:0] add_op(input logic [7:0] a, input logic [7:0] m,
                                         input logic cin, input logic [7:0] fl);
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] f;
    s = {1'b0, a} + {1'b0, m} + {8'h00, cin};
    h = {1'b0, a[3:0]} + {1'b0, m[3:0]} + {4'h0, cin};
    f = fl;
    f[FLAG_V] = (a[7] & m[7] & ~s[7]) | (~a[7] & ~m[7] & s[7]);
    f[FLAG_H] = h[4];
    f[FLAG_N] = s[7];
    f[FLAG_Z] = (s[7:0] == 8'h00);
    f[FLAG_C] = s[8];
    return {f, s[7:0]};
  endfunction : add_op

  function automatic logic [15:0] shift_op(input logic [7:0] v, input logic right,
                                           input logic [7:0] fl);
    logic [7:0] r;
    logic [7:0] f;
    f = fl;
    r = right ? {v[7], v[7:1]} : {v[6:0], 1'b0};
    f[FLAG_C] = right ? v[0] : v[7];
    f[FLAG_N] = r[7];
    f[FLAG_Z] = (r == 8'h00);
    f[FLAG_V] = r[7] ^ f[FLAG_C];
    return {f, r};
  endfunction : shift_op

  function automatic logic [15:0] sext(input logic [7:0] b);
    return {{8{b[7]}}, b};
  endfunction : sext

  // ==========================================================
  // Operand address forming
  always_comb
  begin
    ea = hx_ff;
    unique case (dec_ff.mode)
      direct_mode:             ea = {8'h00, lo};
      full_address_mode:       ea = {hi, lo};
      index_offset_short_mode: ea = hx_ff + {8'h00, lo};
      index_offset_short_postinc_mode: ea = hx_ff + {8'h00, hi};
      index_offset_long_mode:  ea = hx_ff + {hi, lo};
      stack_offset_short_mode: ea = sp_ff + {8'h00, lo};
      stack_offset_long_mode:  ea = sp_ff + {hi, lo};
      default:                 ea = hx_ff;
    endcase
  end

  // ==========================================================
  // Sequencer and datapath next state
  always_comb
  begin
    nxt_st = st_ff;
    nxt_dec = dec_ff;
    nxt_req = '0;
    nxt_a = a_ff;
    nxt_flags = flags_ff;
    nxt_hx = hx_ff;
    nxt_sp = sp_ff;
    nxt_pc = pc_ff;
    nxt_b1 = b1_ff;
    nxt_halt = halt_ff;
    dn = decode(1'b0, mem_rdata);
    go_fetch = 1'b0;
    start_op = 1'b0;
    last_byte = 1'b0;
    res16 = 16'h0000;
    lo = mem_rdata;
    hi = (st_ff == ST_B2) ? b1_ff : 8'h00;
    unique case (st_ff)
      ST_IDLE:
      begin
        nxt_pc = start_pc_ff;
        go_fetch = run_ff;
      end
      ST_OPC:
      begin
        nxt_pc = pc_ff + 16'h0001;
        if (mem_rdata == OPC_PFX_SP)
        begin
          nxt_st = ST_PFX;
          nxt_req = '{addr: nxt_pc, rd: 1'b1, wr: 1'b0, wdata: 8'h00};
        end
        else
          start_op = 1'b1;
      end
      ST_PFX:
      begin
        nxt_pc = pc_ff + 16'h0001;
        dn = decode(1'b1, mem_rdata);
        start_op = 1'b1;
      end
      ST_B1:
      begin
        nxt_pc = pc_ff + 16'h0001;
        nxt_b1 = mem_rdata;
        if (dec_ff.nbytes == 2'd2)
        begin
          nxt_st = ST_B2;
          nxt_req = '{addr: nxt_pc, rd: 1'b1, wr: 1'b0, wdata: 8'h00};
        end
        else
          last_byte = 1'b1;
      end
      ST_B2:
      begin
        nxt_pc = pc_ff + 16'h0001;
        last_byte = 1'b1;
      end
      ST_DATA:
      begin
        unique case (dec_ff.op)
          OP_ADC, OP_ADD:
          begin
            res16 = add_op(a_ff, mem_rdata, (dec_ff.op == OP_ADC) & flags_ff[FLAG_C], flags_ff);
            {nxt_flags, nxt_a} = res16;
            go_fetch = 1'b1;
          end
          shift_left_arith, shift_right_arith:
          begin
            res16 = shift_op(mem_rdata, dec_ff.op == shift_right_arith, flags_ff);
            nxt_flags = res16[15:8];
            nxt_st = ST_WR;
            nxt_req = '{addr: mem_req.addr, rd: 1'b0, wr: 1'b1, wdata: res16[7:0]};
          end
          OP_MOV:
          begin
            nxt_flags[FLAG_V] = 1'b0;
            nxt_flags[FLAG_N] = mem_rdata[7];
            nxt_flags[FLAG_Z] = (mem_rdata == 8'h00);
            nxt_hx = hx_ff + 16'h0001;
            nxt_st = ST_WR;
            nxt_req = '{addr: {8'h00, b1_ff}, rd: 1'b0, wr: 1'b1, wdata: mem_rdata};
          end
          default:
          begin
            nxt_hx = hx_ff + 16'h0001;
            if (a_ff == mem_rdata) nxt_pc = pc_ff + sext(b1_ff);
            go_fetch = 1'b1;
          end
        endcase
      end
      ST_WR, ST_FREE: go_fetch = 1'b1;
      ST_HALT:
      begin
        if (!run_ff)
        begin
          nxt_st = ST_IDLE;
          nxt_halt = 1'b0;
        end
      end
    endcase
    if (start_op)
    begin
      nxt_dec = dn;
      if (dn.op == OP_ILL)
      begin
        nxt_st = ST_HALT;
        nxt_halt = 1'b1;
      end
      else if (dn.nbytes != 2'd0)
      begin
        nxt_st = ST_B1;
        nxt_req = '{addr: nxt_pc, rd: 1'b1, wr: 1'b0, wdata: 8'h00};
      end
      else if (dn.mode == implied_mode)
      begin
        res16 = shift_op(dn.use_x ? hx_ff[7:0] : a_ff, dn.op == shift_right_arith, flags_ff);
        nxt_flags = res16[15:8];
        if (dn.use_x) nxt_hx = {hx_ff[15:8], res16[7:0]};
        else nxt_a = res16[7:0];
        go_fetch = 1'b1;
      end
      else
      begin
        nxt_st = ST_DATA;
        nxt_req = '{addr: hx_ff, rd: 1'b1, wr: 1'b0, wdata: 8'h00};
      end
    end
    if (last_byte)
    begin
      nxt_b1 = lo;
      unique case (dec_ff.op)
        stack_adjust_immediate: nxt_sp = sp_ff + sext(lo);
        index_adjust_immediate: nxt_hx = hx_ff + sext(lo);
        branch_carry_clear: if (!flags_ff[FLAG_C]) nxt_pc = nxt_pc + sext(lo);
        OP_LDHX:
        begin
          nxt_hx = {hi, lo};
          nxt_flags[FLAG_V] = 1'b0;
          nxt_flags[FLAG_N] = hi[7];
          nxt_flags[FLAG_Z] = ({hi, lo} == 16'h0000);
        end
        default: res16 = 16'h0000;
      endcase
      if (dec_ff.op == branch_carry_clear)
        nxt_st = ST_FREE;
      else if (dec_ff.mode == literal_operand_mode && (dec_ff.op == OP_ADC || dec_ff.op == OP_ADD))
      begin
        res16 = add_op(a_ff, lo, (dec_ff.op == OP_ADC) & flags_ff[FLAG_C], flags_ff);
        {nxt_flags, nxt_a} = res16;
        go_fetch = 1'b1;
      end
      else if (dec_ff.mode == literal_operand_mode || dec_ff.mode == literal_long_mode)
        go_fetch = 1'b1;
      else
      begin
        nxt_st = ST_DATA;
        nxt_req = '{addr: ea, rd: 1'b1, wr: 1'b0, wdata: 8'h00};
      end
    end
    // Clearing run stops only at an instruction boundary, never mid-instruction.
    if (go_fetch)
    begin
      nxt_st = run_ff ? ST_OPC : ST_IDLE;
      nxt_req = '{addr: nxt_pc, rd: run_ff, wr: 1'b0, wdata: 8'h00};
    end
  end

  // ==========================================================
  // Sequencer state
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_ff <= ST_IDLE;
      dec_ff <= '{implied_mode, OP_ILL, 2'd0, 1'b0};
      b1_ff <= 8'h00;
      halt_ff <= 1'b0;
      mem_req <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
      dec_ff <= nxt_dec;
      b1_ff <= nxt_b1;
      halt_ff <= nxt_halt;
      mem_req <= nxt_req;
    end
  end

  // ==========================================================
  // Programmer-visible registers
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      a_ff <= 8'h00;
      flags_ff <= FLAGS_RST;
      hx_ff <= HX_RST;
      sp_ff <= SP_RST;
      pc_ff <= PC_RST;
    end
    else
    begin
      a_ff <= nxt_a;
      flags_ff <= nxt_flags;
      hx_ff <= nxt_hx;
      sp_ff <= nxt_sp;
      pc_ff <= nxt_pc;
    end
  end

  // ==========================================================
  // Bus slave, zero wait states
  // Read data is latched in the address phase, so a read right behind a write sees old data.
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_ff <= hsel & hready & htrans[1] & hwrite & (hsize == 3'b010);
      if (hsel && hready && htrans[1])
      begin
        wr_addr_ff <= haddr[7:0];
        unique case (haddr[7:0])
          OFS_CTRL:   hrdata <= {31'h0000_0000, run_ff};
          OFS_START:  hrdata <= {16'h0000, start_pc_ff};
          OFS_STATUS: hrdata <= {14'h0000, st_ff != ST_IDLE, halt_ff, flags_ff, a_ff};
          OFS_PTRS:   hrdata <= {sp_ff, hx_ff};
          OFS_PC:     hrdata <= {16'h0000, pc_ff};
          default:    hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      run_ff <= 1'b0;
      start_pc_ff <= PC_RST;
    end
    else if (wr_pend_ff)
    begin
      if (wr_addr_ff == OFS_CTRL) run_ff <= hwdata[CTRL_RUN];
      if (wr_addr_ff == OFS_START) start_pc_ff <= hwdata[15:0];
    end
  end
endmodule : cpu_operand_decode_alu

// File: dv/cpu_operand_decode_alu_assertions.sv
`timescale 1ns/1ps
module cpu_operand_decode_alu_assertions
(
  input wire logic                     clk_sys,   // Clock
  input wire logic                     reset_n,   // Async reset
  input wire logic                     hreadyout, // Slave ready
  input wire logic                     hresp,     // Response
  input wire cpu_decode_pkg::mem_req_t mem_req,   // Memory request
  input wire logic [7:0]               mem_rdata  // Memory read data
);
  import cpu_decode_pkg::*;
  // ==========================================================
  // Bus checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  property p_ahb_okay;
    hreadyout && !hresp;
  endproperty
  a_ahb_okay: assert property (p_ahb_okay)
    else $error("register bus answer is not zero-wait okay");
  property p_rw_excl;
    !(mem_req.rd && mem_req.wr);
  endproperty
  a_rw_excl: assert property (p_rw_excl)
    else $error("memory read and write in one cycle");
  // ==========================================================
  // Opcode sequences, keyed on the fetched opcode byte
  property p_stack_adj;
    mem_req.rd && mem_rdata == OPC_AIS |=> mem_req.rd && mem_req.addr == $past(mem_req.addr) + 16'h0001
      ##1 mem_req.rd && mem_req.addr == $past(mem_req.addr, 2) + 16'h0002;
  endproperty
  a_stack_adj: assert property (p_stack_adj)
    else $error("stack adjust does not take two cycles");
  property p_index_adj;
    mem_req.rd && mem_rdata == OPC_AIX |=> mem_req.rd && mem_req.addr == $past(mem_req.addr) + 16'h0001
      ##1 mem_req.rd && mem_req.addr == $past(mem_req.addr, 2) + 16'h0002;
  endproperty
  a_index_adj: assert property (p_index_adj)
    else $error("index adjust does not take two cycles");
  property p_branch_cc;
    mem_req.rd && mem_rdata == OPC_BCC |=> mem_req.rd && mem_req.addr == $past(mem_req.addr) + 16'h0001
      ##1 !mem_req.rd && !mem_req.wr ##1 mem_req.rd;
  endproperty
  a_branch_cc: assert property (p_branch_cc)
    else $error("carry-clear branch does not take three cycles");
  property p_full_addr;
    mem_req.rd && mem_rdata == {MN_EXT, NIB_ADD}
      |-> ##3 mem_req.rd && mem_req.addr == {$past(mem_rdata, 2), $past(mem_rdata, 1)};
  endproperty
  a_full_addr: assert property (p_full_addr)
    else $error("full address not formed high byte first");
  property p_direct;
    mem_req.rd && mem_rdata == {MN_DIR, NIB_ADD}
      |-> ##2 mem_req.rd && mem_req.addr == {8'h00, $past(mem_rdata)};
  endproperty
  a_direct: assert property (p_direct)
    else $error("direct operand read outside page zero");
  property p_move_pi;
    mem_req.rd && mem_rdata == OPC_MOV_XP
      |-> ##3 mem_req.wr && mem_req.addr == {8'h00, $past(mem_rdata, 2)};
  endproperty
  a_move_pi: assert property (p_move_pi)
    else $error("move destination address wrong");
  property p_literal;
    mem_req.rd && mem_rdata == OPC_LDHX_I |=> mem_req.addr == $past(mem_req.addr) + 16'h0001
      ##1 mem_req.addr == $past(mem_req.addr, 2) + 16'h0002
      ##1 mem_req.rd && mem_req.addr == $past(mem_req.addr, 3) + 16'h0003;
  endproperty
  a_literal: assert property (p_literal)
    else $error("long literal not read as two bytes");
  property p_shift_dir;
    mem_req.rd && mem_rdata == {SN_DIR, NIB_ASL} |-> ##3 mem_req.wr
      && mem_req.addr == {8'h00, $past(mem_rdata, 2)} && mem_req.wdata == ($past(mem_rdata) << 1);
  endproperty
  a_shift_dir: assert property (p_shift_dir)
    else $error("memory shift left wrote wrong value");
endmodule : cpu_operand_decode_alu_assertions

bind cpu_operand_decode_alu cpu_operand_decode_alu_assertions i_cpu_operand_decode_alu_assertions (
  .clk_sys(clk_sys), .reset_n(reset_n), .hreadyout(hreadyout), .hresp(hresp),
  .mem_req(mem_req), .mem_rdata(mem_rdata));

// File: dv/mem_model.sv
`timescale 1ns/1ps
module mem_model
(
  input wire logic                     clk_sys,  // Clock
  input wire cpu_decode_pkg::mem_req_t mem_req,  // Request from core
  output logic [7:0]                   mem_rdata // Read data
);
  import cpu_decode_pkg::*;
  logic [7:0] mem [0:65535];
  logic [7:0] last_ff;
  // Unrequested reads show the inverse of the last byte, so no stale value can pass.
  assign mem_rdata = mem_req.rd ? mem[mem_req.addr] : ~last_ff;
  initial
  begin
    last_ff = 8'h00;
    for (int i = 0; i < 65536; i++) mem[i] = 8'h00;
  end
  always @(posedge clk_sys)
  begin
    if (mem_req.rd) last_ff <= mem[mem_req.addr];
    if (mem_req.wr) mem[mem_req.addr] <= mem_req.wdata;
  end
endmodule : mem_model

// File: dv/cpu_operand_decode_alu_test.sv
`timescale 1ns/1ps
module cpu_operand_decode_alu_test;
  import cpu_decode_pkg::*;
  logic        clk_sys, reset_n, hsel, hwrite;
  logic [31:0] haddr, hwdata, hrdata, rd_val;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        hreadyout, hresp;
  wire logic   hready;
  mem_req_t    mem_req;
  logic [7:0]  mem_rdata;
  int          err_count, samples_checked;
  // Row: program bytes, STATUS[15:0], PTRS, probe address, probe byte.
  logic [167:0] rows [0:17];
  assign hready = hreadyout;
  always #5 clk_sys = ~clk_sys;
  cpu_operand_decode_alu i_cpu_operand_decode_alu (.clk_sys(clk_sys), .reset_n(reset_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .mem_req(mem_req), .mem_rdata(mem_rdata));
  mem_model i_mem_model (.clk_sys(clk_sys), .mem_req(mem_req), .mem_rdata(mem_rdata));
  // ==========================================================
  // Tasks
  task wrap_up;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task wait_rdy;
    int n;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 64);
    if (hreadyout !== 1'b1)
    begin
      err_count++;
      wrap_up();
    end
  endtask : wait_rdy
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    htrans <= 2'b10;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    rd_val = hrdata;
  endtask : xfer
  task do_reset;
    reset_n <= 1'b0;
    repeat (6) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
  endtask : do_reset
  task run_row(input logic [167:0] r);
    int n;
    do_reset();
    for (int i = 0; i < 12; i++) i_mem_model.mem[16'h0100 + i] = r[167 - 8 * i -: 8];
    xfer(1'b1, OFS_START, 32'h0000_0100);
    xfer(1'b1, OFS_CTRL, 32'h0000_0001);
    n = 0;
    do
    begin
      xfer(1'b0, OFS_STATUS, 32'h0000_0000);
      n++;
    end
    while (rd_val[STAT_HALT] !== 1'b1 && n < 100);
    chk({14'h0000, rd_val[17:0]}, {15'h0001, 1'b1, r[71:56]});
    if (rd_val[STAT_HALT] !== 1'b1) wrap_up();
    xfer(1'b0, OFS_PTRS, 32'h0000_0000);
    chk(rd_val, r[55:24]);
    chk({24'h00_0000, i_mem_model.mem[r[23:8]]}, {24'h00_0000, r[7:0]});
  endtask : run_row
  // ==========================================================
  // Main sequence
  initial
  begin
    clk_sys = 1'b0;
    reset_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
    err_count = 0;
    samples_checked = 0;
    rows[0] = {96'hA780_0000_0000_0000_0000_0000, 16'h0800, 32'h007F_0000, 16'h0040, 8'h11};
    rows[1] = {96'h4512_34AF_7F00_0000_0000_0000, 16'h0800, 32'h00FF_12B3, 16'h0040, 8'h11};
    rows[2] = {96'hAB7F_AB01_0000_0000_0000_0000, 16'h9C80, 32'h00FF_0000, 16'h0040, 8'h11};
    rows[3] = {96'hABFF_AB01_A900_0000_0000_0000, 16'h0801, 32'h00FF_0000, 16'h0040, 8'h11};
    rows[4] = {96'hCB12_34CB_F000_0000_0000_0000, 16'h0826, 32'h00FF_0000, 16'h0040, 8'h11};
    rows[5] = {96'hBB40_0000_0000_0000_0000_0000, 16'h0811, 32'h00FF_0000, 16'h0040, 8'h11};
    rows[6] = {96'h45FF_F0DB_0020_0000_0000_0000, 16'h0833, 32'h00FF_FFF0, 16'h0040, 8'h11};
    rows[7] = {96'h4512_00EB_F000_0000_0000_0000, 16'h0844, 32'h00FF_1200, 16'h0040, 8'h11};
    rows[8] = {96'h9EEB_F000_0000_0000_0000_0000, 16'h0866, 32'h00FF_0000, 16'h0040, 8'h11};
    rows[9] = {96'h9EDB_1200_0000_0000_0000_0000, 16'h0808, 32'h00FF_0000, 16'h0040, 8'h11};
    rows[10] = {96'hAB01_2402_AB10_AB20_0000_0000, 16'h0821, 32'h00FF_0000, 16'h0040, 8'h11};
    rows[11] = {96'hABFF_AB01_2402_AB10_0000_0000, 16'h0810, 32'h00FF_0000, 16'h0040, 8'h11};
    rows[12] = {96'hAB81_4800_0000_0000_0000_0000, 16'h8902, 32'h00FF_0000, 16'h0040, 8'h11};
    rows[13] = {96'hAB81_4700_0000_0000_0000_0000, 16'h0DC0, 32'h00FF_0000, 16'h0040, 8'h11};
    rows[14] = {96'h4500_607E_7038_5000_0000_0000, 16'h0D00, 32'h00FF_0061, 16'h0050, 8'h86};
    rows[15] = {96'h4500_60AB_AA71_02AB_01AB_0200, 16'h0CAC, 32'h00FF_0061, 16'h0060, 8'hAA};
    rows[16] = {96'h4500_30AB_1161_1002_AB01_AB02, 16'h0813, 32'h00FF_0031, 16'h0040, 8'h11};
    rows[17] = {96'h4500_40FB_5867_C000_0000_0000, 16'h0D11, 32'h00FF_0080, 16'h0140, 8'hCC};
    @(posedge clk_sys);
    // Decoy bytes sit where a wrong byte order, sign or page would read.
    i_mem_model.mem[16'h1234] = 8'h05;
    i_mem_model.mem[16'h3412] = 8'h50;
    i_mem_model.mem[16'hF000] = 8'h21;
    i_mem_model.mem[16'h0040] = 8'h11;
    i_mem_model.mem[16'h0140] = 8'h99;
    i_mem_model.mem[16'h0010] = 8'h33;
    i_mem_model.mem[16'h12F0] = 8'h44;
    i_mem_model.mem[16'h11F0] = 8'h55;
    i_mem_model.mem[16'h01EF] = 8'h66;
    i_mem_model.mem[16'h00EF] = 8'h77;
    i_mem_model.mem[16'h12FF] = 8'h08;
    i_mem_model.mem[16'h0050] = 8'hC3;
    i_mem_model.mem[16'h0060] = 8'hAA;
    for (int k = 0; k < 18; k++) run_row(rows[k]);
    // ==========================================================
    // Leaving halt, then a reset in mid-run
    xfer(1'b1, OFS_CTRL, 32'h0000_0000);
    // The halted flag drops one cycle after the run bit falls.
    @(posedge clk_sys);
    xfer(1'b0, OFS_STATUS, 32'h0000_0000);
    chk({31'h0000_0000, rd_val[STAT_HALT]}, 32'h0000_0000);
    xfer(1'b1, OFS_CTRL, 32'h0000_0001);
    // Let the core start fetching so the reset lands inside an instruction.
    repeat (4) @(posedge clk_sys);
    do_reset();
    xfer(1'b0, OFS_STATUS, 32'h0000_0000);
    chk(rd_val, 32'h0000_0800);
    xfer(1'b0, OFS_PTRS, 32'h0000_0000);
    chk(rd_val, 32'h00FF_0000);
    xfer(1'b0, OFS_PC, 32'h0000_0000);
    chk(rd_val, 32'h0000_0000);
    xfer(1'b0, 8'h20, 32'h0000_0000);
    chk(rd_val, 32'h0000_0000);
    // Status is read-only; a write must leave it alone.
    xfer(1'b1, OFS_STATUS, 32'hFFFF_FFFF);
    xfer(1'b0, OFS_STATUS, 32'h0000_0000);
    chk(rd_val, 32'h0000_0800);
    xfer(1'b1, OFS_START, 32'h0000_1234);
    xfer(1'b0, OFS_START, 32'h0000_0000);
    chk(rd_val, 32'h0000_1234);
    wrap_up();
  end
endmodule : cpu_operand_decode_alu_test
